// ==== amsq_consts.vh ====
`ifndef AMSQ_CONSTS_VH
`define AMSQ_CONSTS_VH
// Register byte offsets, converter 0 at 0x00, converter 1 at 0x40
`define AMSQ_UNIT_STRIDE   12'h040
`define AMSQ_OFF_CTRL0     12'h000
`define AMSQ_OFF_CTRL1     12'h004
`define AMSQ_OFF_CTRL2     12'h008
`define AMSQ_OFF_STATUS    12'h00c
`define AMSQ_OFF_RESULT0   12'h020
// Control register 0 fields
`define AMSQ_C0_CH_LSB     0
`define AMSQ_C0_MODE_LSB   3
`define AMSQ_C0_TRIG_BIT   5
`define AMSQ_C0_START_BIT  6
// Control register 1 fields
`define AMSQ_C1_SWEEP_LSB  0
`define AMSQ_C1_RSWEEP1    2
`define AMSQ_C1_RES10_BIT  3
// Control register 2 fields
`define AMSQ_C2_SH_BIT     0
`define AMSQ_C2_CAUSE_LSB  5
// Reset values
`define AMSQ_CTRL0_RST     8'h00
`define AMSQ_CTRL1_RST     8'h00
`define AMSQ_CTRL2_RST     8'h00
// Operation modes
`define AMSQ_MODE_ONESHOT  2'h0
`define AMSQ_MODE_REPEAT   2'h1
`define AMSQ_MODE_SWEEP    2'h2
`define AMSQ_MODE_RSWEEP   2'h3
// Trigger causes
`define AMSQ_CAUSE_PIN     2'h0
`define AMSQ_CAUSE_OFCO    2'h1
`define AMSQ_CAUSE_IIO     2'h2
// Conversion lengths in conversion-clock cycles
`define AMSQ_CYC_8_NOSH    7'd49
`define AMSQ_CYC_10_NOSH   7'd59
`define AMSQ_CYC_8_SH      7'd28
`define AMSQ_CYC_10_SH     7'd33
`endif

// ==== amsq_unit.v ====
`timescale 1ns/1ps
`include "amsq_consts.vh"

// One converter: control state, sequencing and result storage
module amsq_unit
(
   // Clock and reset
   input  wire        sys_clk,
   input  wire        rst_n,
   // Configuration
   input  wire [7:0]  ctrl0,
   input  wire [7:0]  ctrl1,
   input  wire [7:0]  ctrl2,
   input  wire        start_wr,
   input  wire        stop_wr,
   input  wire        ext_trig,
   input  wire        conv_tick,
   // Analog core
   input  wire [9:0]  analog_sample,
   output wire [2:0]  conv_channel,
   output wire        converting,
   // Results and status
   input  wire [2:0]  rd_index,
   output wire [9:0]  rd_result,
   output wire        start_clear,
   output reg         conv_irq,
   output wire        busy
);

   localparam ST_IDLE = 1'b0;
   localparam ST_CONV = 1'b1;

   reg        state_ff;
   reg [2:0]  chan_ff;
   reg [6:0]  cyc_ff;
   reg [2:0]  main_ff;
   reg        emph_turn_ff;
   reg [9:0]  result_ff [0:7];

   wire [1:0] mode      = ctrl0[`AMSQ_C0_MODE_LSB+1:`AMSQ_C0_MODE_LSB];
   wire       trig_ext  = ctrl0[`AMSQ_C0_TRIG_BIT];
   wire       rsweep1   = ctrl1[`AMSQ_C1_RSWEEP1];
   wire [1:0] sw_sel    = ctrl1[`AMSQ_C1_SWEEP_LSB+1:`AMSQ_C1_SWEEP_LSB];
   wire       res10     = ctrl1[`AMSQ_C1_RES10_BIT];
   wire       sh_en     = ctrl2[`AMSQ_C2_SH_BIT];
   wire [6:0] conv_len  = sh_en ? (res10 ? `AMSQ_CYC_10_SH : `AMSQ_CYC_8_SH)
                                : (res10 ? `AMSQ_CYC_10_NOSH : `AMSQ_CYC_8_NOSH);
   wire [2:0] sweep_last = {sw_sel, 1'b1};
   wire [2:0] emph_last  = {1'b0, sw_sel};
   // Repeat sweep modes accept only the software write
   wire       ext_ok    = trig_ext && (mode != `AMSQ_MODE_RSWEEP);
   // Under external trigger the software write only arms the flag
   wire       start_evt = ext_ok ? ext_trig : start_wr;
   wire       conv_done = (state_ff == ST_CONV) && conv_tick && (cyc_ff == conv_len - 7'd1);
   wire       single_md = (mode == `AMSQ_MODE_ONESHOT);
   wire       sweep_md  = (mode == `AMSQ_MODE_SWEEP);

   reg        nxt_state;
   reg [2:0]  nxt_chan;
   reg [2:0]  nxt_main;
   reg        nxt_emph;
   reg        finish;

   always @*
   begin
      nxt_state = state_ff;
      nxt_chan  = chan_ff;
      nxt_main  = main_ff;
      nxt_emph  = emph_turn_ff;
      finish    = 1'b0;
      if (stop_wr)
      begin
         nxt_state = ST_IDLE;
      end
      else if (state_ff == ST_IDLE)
      begin
         if (start_evt)
         begin
            nxt_state = ST_CONV;
            nxt_chan  = (single_md || mode == `AMSQ_MODE_REPEAT) ?
                        ctrl0[`AMSQ_C0_CH_LSB+2:`AMSQ_C0_CH_LSB] : 3'h0;
            nxt_main  = emph_last + 3'h1;
            nxt_emph  = 1'b1;
         end
      end
      else if (conv_done)
      begin
         case (mode)
            `AMSQ_MODE_ONESHOT:
            begin
               nxt_state = ST_IDLE;
               finish    = 1'b1;
            end
            `AMSQ_MODE_REPEAT:
            begin
               nxt_chan = chan_ff;
            end
            `AMSQ_MODE_SWEEP:
            begin
               if (chan_ff == sweep_last)
               begin
                  nxt_state = ST_IDLE;
                  finish    = 1'b1;
               end
               else
                  nxt_chan = chan_ff + 3'h1;
            end
            default:
            begin
               if (!rsweep1)
                  nxt_chan = (chan_ff == sweep_last) ? 3'h0 : chan_ff + 3'h1;
               else if (emph_turn_ff && chan_ff != emph_last)
                  nxt_chan = chan_ff + 3'h1;
               else if (emph_turn_ff)
               begin
                  // Emphasised group done, one other input follows
                  if (emph_last == 3'h7)
                     nxt_chan = 3'h0;
                  else
                  begin
                     nxt_chan = main_ff;
                     nxt_emph = 1'b0;
                     nxt_main = (main_ff == 3'h7) ? emph_last + 3'h1 : main_ff + 3'h1;
                  end
               end
               else
               begin
                  nxt_chan = 3'h0;
                  nxt_emph = 1'b1;
               end
            end
         endcase
      end
   end

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff     <= ST_IDLE;
         chan_ff      <= 3'h0;
         main_ff      <= 3'h0;
         emph_turn_ff <= 1'b0;
         cyc_ff       <= 7'h00;
         conv_irq     <= 1'b0;
      end
      else
      begin
         state_ff     <= nxt_state;
         chan_ff      <= nxt_chan;
         main_ff      <= nxt_main;
         emph_turn_ff <= nxt_emph;
         conv_irq     <= finish && (single_md || sweep_md);
         if (state_ff == ST_IDLE || conv_done || stop_wr)
            cyc_ff <= 7'h00;
         else if (conv_tick)
            cyc_ff <= cyc_ff + 7'h01;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_res
         always @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
               result_ff[g] <= 10'h000;
            else if (conv_done && !stop_wr && chan_ff == g)
               result_ff[g] <= res10 ? analog_sample : {2'h0, analog_sample[9:2]};
         end
      end
   endgenerate

   assign rd_result    = result_ff[rd_index];
   assign conv_channel = chan_ff;
   assign converting   = (state_ff == ST_CONV);
   assign busy         = (state_ff == ST_CONV);
   // Flag stays set under external trigger so the next event restarts
   assign start_clear  = finish && !trig_ext;

endmodule // amsq_unit

// ==== amsq_top.v ====
`timescale 1ns/1ps
`include "amsq_consts.vh"

// Summary of operation
// - One-shot converts selected input once
// - Start flag clears at end unless external
// - Writing start flag zero stops conversion
// - One-shot raises interrupt on completion
// - Repeat converts input forever, no interrupt
// - Single sweep once, interrupt at end
// - Sweep set is 2, 4, 6, 8 inputs
// - Repeat sweep 0 software start only
// - Repeat sweep 1 all inputs, software start
// - Emphasised set is 1 to 4 inputs
// - Each input has its own result register
// - Ten-bit or eight-bit result placement
// - Sample-and-hold gives 28 or 33 cycles
// - Trigger select picks software or external
// - Cause 00 pin, 01 timer, 10 channel
// - Timer cause only in three-phase PWM
// - Without hold 49 or 59 cycles
// - Mode field encoding and sweep variant bit
module amsq_top
#(
   parameter AD_DIV = 4
)
(
   // Clock and reset
   input  wire        sys_clk,
   input  wire        resetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Trigger sources
   input  wire        ext_conv_trigger_pin,
   input  wire        occurrence_counter_overflow_irq,
   input  wire        three_phase_pwm_mode,
   input  wire        iio_grp2_ch1_irq,
   input  wire        iio_grp3_ch1_irq,
   // Analog cores
   input  wire [19:0] analog_sample,
   output wire [5:0]  conv_channel,
   output wire [1:0]  converting,
   // Conversion interrupt requests
   output wire [1:0]  conv_irq
);

   reg  [1:0]  rst_sync_ff;
   wire        rst_n = rst_sync_ff[1];

   always @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         rst_sync_ff <= 2'b00;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end

   // Pin-level trigger sources pass three flops
   reg  [4:0]  trig_s1_ff;
   reg  [4:0]  trig_s2_ff;
   reg  [4:0]  trig_s3_ff;
   wire [4:0]  trig_raw = {iio_grp3_ch1_irq, iio_grp2_ch1_irq, three_phase_pwm_mode,
                           occurrence_counter_overflow_irq, ext_conv_trigger_pin};

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trig_s1_ff <= 5'h00;
         trig_s2_ff <= 5'h00;
         trig_s3_ff <= 5'h00;
      end
      else
      begin
         trig_s1_ff <= trig_raw;
         trig_s2_ff <= trig_s1_ff;
         trig_s3_ff <= trig_s2_ff;
      end
   end

   // Trigger pin is active on its falling edge; others on rising
   wire pin_evt  = trig_s3_ff[0] && !trig_s2_ff[0];
   wire ofco_evt = trig_s2_ff[1] && !trig_s3_ff[1] && trig_s2_ff[2];
   wire iio2_evt = trig_s2_ff[3] && !trig_s3_ff[3];
   wire iio3_evt = trig_s2_ff[4] && !trig_s3_ff[4];

   // Conversion clock divider shared by both converters
   reg  [7:0]  div_ff;
   wire        conv_tick = (div_ff == AD_DIV[7:0] - 8'h01);

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         div_ff <= 8'h00;
      else if (conv_tick)
         div_ff <= 8'h00;
      else
         div_ff <= div_ff + 8'h01;
   end

   wire        acc      = psel && penable;
   wire        wr_acc   = acc && pwrite;
   wire        unit_sel = paddr[6];
   wire [5:0]  reg_off  = paddr[5:0];
   wire [2:0]  rd_index = paddr[4:2];

   reg  [7:0]  ctrl0_ff [0:1];
   reg  [7:0]  ctrl1_ff [0:1];
   reg  [7:0]  ctrl2_ff [0:1];
   wire [9:0]  rd_result [0:1];
   wire [1:0]  busy;
   reg  [31:0] rdata;
   reg         mapped;

   genvar u;
   generate
      for (u = 0; u < 2; u = u + 1)
      begin : g_unit
         wire hit     = wr_acc && (paddr[11:7] == 5'h00) && (unit_sel == u);
         wire wr_c0   = hit && ({6'h00, reg_off} == `AMSQ_OFF_CTRL0);
         wire wr_c1   = hit && ({6'h00, reg_off} == `AMSQ_OFF_CTRL1);
         wire wr_c2   = hit && ({6'h00, reg_off} == `AMSQ_OFF_CTRL2);
         wire start_w = wr_c0 && pwdata[`AMSQ_C0_START_BIT] && !busy[u];
         wire stop_w  = wr_c0 && !pwdata[`AMSQ_C0_START_BIT];
         wire [1:0] cause = ctrl2_ff[u][`AMSQ_C2_CAUSE_LSB+1:`AMSQ_C2_CAUSE_LSB];
         reg  ext_evt;
         wire clr_flag;
         // Start waits a cycle so the unit sees the new control word
         reg  start_q_ff;

         always @*
         begin
            case (cause)
               `AMSQ_CAUSE_PIN:  ext_evt = pin_evt;
               `AMSQ_CAUSE_OFCO: ext_evt = ofco_evt;
               `AMSQ_CAUSE_IIO:  ext_evt = (u == 0) ? iio2_evt : iio3_evt;
               default:          ext_evt = 1'b0;
            endcase
         end

         always @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               ctrl0_ff[u] <= `AMSQ_CTRL0_RST;
               ctrl1_ff[u] <= `AMSQ_CTRL1_RST;
               ctrl2_ff[u] <= `AMSQ_CTRL2_RST;
               start_q_ff  <= 1'b0;
            end
            else
            begin
               if (wr_c0)
                  ctrl0_ff[u] <= pwdata[7:0];
               else if (clr_flag)
                  ctrl0_ff[u][`AMSQ_C0_START_BIT] <= 1'b0;
               if (wr_c1)
                  ctrl1_ff[u] <= pwdata[7:0];
               if (wr_c2)
                  ctrl2_ff[u] <= pwdata[7:0];
               start_q_ff <= start_w;
            end
         end

         // External events only count once the start flag is armed
         amsq_unit u_unit
         (
            .sys_clk       (sys_clk),
            .rst_n         (rst_n),
            .ctrl0         (ctrl0_ff[u]),
            .ctrl1         (ctrl1_ff[u]),
            .ctrl2         (ctrl2_ff[u]),
            .start_wr      (start_q_ff),
            .stop_wr       (stop_w),
            .ext_trig      (ext_evt && ctrl0_ff[u][`AMSQ_C0_START_BIT]),
            .conv_tick     (conv_tick),
            .analog_sample (analog_sample[u*10 +: 10]),
            .conv_channel  (conv_channel[u*3 +: 3]),
            .converting    (converting[u]),
            .rd_index      (rd_index),
            .rd_result     (rd_result[u]),
            .start_clear   (clr_flag),
            .conv_irq      (conv_irq[u]),
            .busy          (busy[u])
         );
      end
   endgenerate

   always @*
   begin
      rdata  = 32'h0000_0000;
      mapped = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0);
      if ({6'h00, reg_off} == `AMSQ_OFF_CTRL0)
         rdata[7:0] = ctrl0_ff[unit_sel];
      else if ({6'h00, reg_off} == `AMSQ_OFF_CTRL1)
         rdata[7:0] = ctrl1_ff[unit_sel];
      else if ({6'h00, reg_off} == `AMSQ_OFF_CTRL2)
         rdata[7:0] = ctrl2_ff[unit_sel];
      else if ({6'h00, reg_off} == `AMSQ_OFF_STATUS)
         rdata[0] = busy[unit_sel];
      else if (reg_off[5])
         // Whole ten-bit result in one word, one word per input
         rdata[9:0] = rd_result[unit_sel];
      else
         mapped = 1'b0;
   end

   reg [31:0] prdata_ff;

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         prdata_ff <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata_ff <= rdata;
   end

   assign prdata  = prdata_ff;
   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;

endmodule // amsq_top

// ==== amsq_checker.sv ====
`timescale 1ns/1ps
module amsq_checker
(
   // Clock and reset
   input wire        sys_clk,
   input wire        resetn,
   // APB
   input wire        psel,
   input wire        penable,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // Converter outputs
   input wire [1:0]  converting,
   input wire [1:0]  conv_irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   chk_ready_high: assert property (pready)
      else $error("pready low");
   chk_err_access: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access phase");
   chk_rdata_hold: assert property (!$past(psel && !penable) |-> $stable(prdata))
      else $error("prdata changed without a setup cycle");
   chk_irq0_pulse: assert property (conv_irq[0] |=> !conv_irq[0])
      else $error("unit 0 irq longer than one cycle");
   chk_irq1_pulse: assert property (conv_irq[1] |=> !conv_irq[1])
      else $error("unit 1 irq longer than one cycle");
   chk_irq0_idle: assert property ($rose(conv_irq[0]) |-> !converting[0])
      else $error("unit 0 irq while converting");
   chk_irq1_idle: assert property ($rose(conv_irq[1]) |-> !converting[1])
      else $error("unit 1 irq while converting");
   // Shortest conversion is 28 cycles, so 8 is a safe floor at any divider
   chk_conv0_len: assert property ($rose(converting[0]) |-> converting[0] [*8])
      else $error("unit 0 conversion too short");
   chk_conv1_len: assert property ($rose(converting[1]) |-> converting[1] [*8])
      else $error("unit 1 conversion too short");
endmodule // amsq_checker

bind amsq_top amsq_checker i_amsq_checker
(
   .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .converting(converting), .conv_irq(conv_irq)
);

// ==== amsq_far.sv ====
`timescale 1ns/1ps
module amsq_far
(
   // Clock
   input  wire        sys_clk,
   // Bench control
   input  wire [9:0]  base,
   input  wire [3:0]  fire,
   // Towards the converters
   input  wire [5:0]  conv_channel,
   output wire [19:0] analog_sample,
   output wire        trig_pin_n,
   output reg  [2:0]  trig_evt
);
   reg [1:0] pin_cnt_ff;

   initial pin_cnt_ff = 2'h0;
   initial trig_evt = 3'h0;
   // Level differs per channel so a misplaced result shows
   assign analog_sample = {base ^ {conv_channel[5:3], 7'h00},
                           base ^ {conv_channel[2:0], 7'h00}};
   // Pin idles high; a trigger is a three-cycle low pulse
   assign trig_pin_n = (pin_cnt_ff == 2'h0);
   always @(posedge sys_clk)
   begin
      pin_cnt_ff <= fire[0] ? 2'h3 : (pin_cnt_ff != 2'h0 ? pin_cnt_ff - 2'h1 : 2'h0);
      trig_evt   <= fire[3:1];
   end
endmodule // amsq_far

// ==== amsq_top_bench.sv ====
`timescale 1ns/1ps
module amsq_top_bench;
   localparam int DIV = 1;
   logic        sys_clk = 1'b0;
   logic        resetn  = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic        pwm     = 1'b0;
   logic [9:0]  base    = 10'h000;
   logic [3:0]  fire    = 4'h0;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire         trig_pin_n;
   wire  [2:0]  trig_evt;
   wire  [19:0] analog_sample;
   wire  [5:0]  conv_channel;
   wire  [1:0]  converting;
   wire  [1:0]  conv_irq;
   int          mismatches = 0;
   int          comparisons = 0;
   int          irq_cnt[2] = '{0, 0};
   int          su = 0;
   logic [2:0]  seq[$];
   logic [31:0] rd;
   logic        er;

   always #12.5 sys_clk = ~sys_clk;

   amsq_top #(.AD_DIV(DIV)) i_amsq_top
   (
      .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_conv_trigger_pin(trig_pin_n),
      .occurrence_counter_overflow_irq(trig_evt[0]), .three_phase_pwm_mode(pwm),
      .iio_grp2_ch1_irq(trig_evt[1]), .iio_grp3_ch1_irq(trig_evt[2]),
      .analog_sample(analog_sample), .conv_channel(conv_channel),
      .converting(converting), .conv_irq(conv_irq)
   );
   amsq_far i_amsq_far
   (
      .sys_clk(sys_clk), .base(base), .fire(fire), .conv_channel(conv_channel),
      .analog_sample(analog_sample), .trig_pin_n(trig_pin_n), .trig_evt(trig_evt)
   );

   // Channel order is logged only on change, enough for sweep modes
   always @(posedge sys_clk)
   begin
      for (int u = 0; u < 2; u++)
         if (conv_irq[u] === 1'b1)
            irq_cnt[u]++;
      if (converting[su] === 1'b1 && (seq.size() == 0 || conv_channel[su*3+:3] !== seq[$]))
         seq.push_back(conv_channel[su*3+:3]);
   end

   function automatic logic [31:0] res(input logic [2:0] c, input bit r10);
      logic [9:0] v;
      v = base ^ {c, 7'h00};
      return r10 ? {22'h0, v} : {24'h0, v[9:2]};
   endfunction
   function automatic int clen(input bit r10, input bit sh);
      return DIV * (sh ? (r10 ? 33 : 28) : (r10 ? 59 : 49));
   endfunction
   function automatic int rs_exp(input int m, input int s, input int i);
      if (m == 0)
         return i % (2 * s + 2);
      if (i % (s + 2) <= s)
         return i % (s + 2);
      return s + 1 + (i / (s + 2)) % (7 - s);
   endfunction

   task automatic test_done();
      if (mismatches == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         $display("unexpected %s: expected %h seen %h", nm, e, g);
         mismatches++;
      end
   endtask
   task automatic hang(input string nm);
      $display("unexpected %s: expected response seen timeout", nm);
      mismatches++;
      test_done();
   endtask
   task automatic apb(input bit w, input int u, input logic [11:0] off, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= off + (u ? 12'h040 : 12'h000);
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
         hang("pready");
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input int u, input logic [11:0] off, input logic [31:0] d);
      apb(1'b1, u, off, d);
   endtask
   task automatic chk(input int u, input logic [11:0] off, input logic [31:0] e, input string nm);
      apb(1'b0, u, off, 32'h0);
      cmp(nm, e, rd);
   endtask
   task automatic run(input int u, input int len);
      int n;
      n = 0;
      while (converting[u] !== 1'b1 && n < 40)
      begin
         @(posedge sys_clk);
         #1 n++;
      end
      if (converting[u] !== 1'b1)
         hang("converting");
      n = 0;
      while (converting[u] === 1'b1 && n < 400)
      begin
         @(posedge sys_clk);
         #1 n++;
      end
      cmp("conv_len", len, n);
   endtask
   task automatic pulse(input int i);
      @(posedge sys_clk);
      fire[i] <= 1'b1;
      @(posedge sys_clk);
      fire[i] <= 1'b0;
   endtask

   initial
   begin
      int u, ch, s, n, n0;
      void'($urandom(83));
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      for (int k = 0; k < 6; k++)
         chk(k / 3, 12'(4 * (k % 3)), 32'h0, "ctrl_reset");
      apb(1'b0, 0, 12'h010, 32'h0);
      cmp("unmapped_err", 32'h1, {31'h0, er});
      cmp("unmapped_data", 32'h0, rd);
      for (int k = 0; k < 4; k++)
      begin
         u = $urandom_range(1);
         ch = $urandom_range(7);
         base <= 10'($urandom);
         wr(u, 12'h004, 32'(k[1]) << 3);
         wr(u, 12'h008, 32'(k[0]));
         n0 = irq_cnt[u];
         wr(u, 12'h000, 32'h40 | ch);
         run(u, clen(k[1], k[0]));
         repeat (3) @(posedge sys_clk);
         cmp("irq_count", n0 + 1, irq_cnt[u]);
         cmp("idle", 0, converting[u]);
         chk(u, 12'h000, ch, "start_clear");
         chk(u, 12'h020 + 12'(4 * ch), res(ch, k[1]), "result");
      end
      for (s = 0; s < 4; s++)
      begin
         u = s % 2;
         su = u;
         base <= 10'($urandom);
         wr(u, 12'h004, s);
         wr(u, 12'h008, 32'h0);
         seq.delete();
         n0 = irq_cnt[u];
         wr(u, 12'h000, 32'h50);
         for (n = 0; n < 3000 && irq_cnt[u] == n0; n++)
            @(posedge sys_clk);
         repeat (3) @(posedge sys_clk);
         cmp("irq_count", n0 + 1, irq_cnt[u]);
         cmp("sweep_len", 2 * s + 2, seq.size());
         foreach (seq[i])
            cmp("sweep_ch", i, seq[i]);
         chk(u, 12'h024 + 12'(8 * s), res(3'(2 * s + 1), 0), "sweep_result");
      end
      for (int c = 0; c < 3; c++)
      begin
         u = $urandom_range(1);
         ch = $urandom_range(7);
         wr(u, 12'h004, 32'h0);
         wr(u, 12'h008, c << 5);
         wr(u, 12'h000, 32'h60 | ch);
         if (c == 1)
            pulse(1);
         if (c == 2)
            pulse(3 - u);
         repeat (10) @(posedge sys_clk);
         cmp("no_start", 0, converting[u]);
         pwm <= 1'b1;
         pulse(c == 2 ? 2 + u : c);
         run(u, clen(0, 0));
         chk(u, 12'h000, 32'h60 | ch, "start_kept");
         wr(u, 12'h000, 32'h0);
         pwm <= 1'b0;
      end
      n0 = irq_cnt[1];
      wr(1, 12'h008, 32'h1);
      wr(1, 12'h000, 32'h4b);
      repeat (200) @(posedge sys_clk);
      cmp("repeat_busy", 1, converting[1]);
      chk(1, 12'h00c, 32'h1, "status_busy");
      wr(1, 12'h000, 32'h08);
      repeat (3) @(posedge sys_clk);
      cmp("stopped", 0, converting[1]);
      cmp("irq_count", n0, irq_cnt[1]);
      for (int m = 0; m < 2; m++)
      begin
         s = $urandom_range(3);
         su = m;
         wr(m, 12'h008, 32'h0);
         wr(m, 12'h004, (m << 2) | s);
         seq.delete();
         n0 = irq_cnt[m];
         wr(m, 12'h000, 32'h58);
         for (n = 0; n < 3000 && seq.size() < 12; n++)
            @(posedge sys_clk);
         wr(m, 12'h000, 32'h0);
         if (seq.size() < 12)
            hang("sweep_seq");
         for (int i = 0; i < 12; i++)
            cmp("rsweep_ch", rs_exp(m, s, i), seq[i]);
         cmp("irq_count", n0, irq_cnt[m]);
      end
      test_done();
   end
endmodule // amsq_top_bench
